// ### rtl/compare_single_event_stagger_pkg.sv
`default_nettype none
package compare_single_event_stagger_pkg;

  // ****************************************
  // sizes and timing counts
  // ****************************************
  localparam int CH_N          = 16;
  localparam int LANE_N        = 8;
  localparam int SLOT_W        = 3;
  localparam int OP_CYCLE_CLKS = 8;
  localparam int ADDR_W        = 20;

  // ****************************************
  // register indices, byte address is four times these
  // ****************************************
  localparam logic [15:0] IDX_ARM    = 16'hfe2a;
  localparam logic [15:0] IDX_SELECT = 16'hfe2c;
  localparam logic [15:0] IDX_IOC1   = 16'hf062;
  localparam logic [15:0] IDX_IOC2   = 16'hf066;
  localparam logic [15:0] IDX_STATUS = 16'hfe30;

  // ****************************************
  // reset values and field layout
  // ****************************************
  localparam logic [15:0] REG_RESET   = 16'h0000;
  localparam logic [15:0] IOC_RW_MASK = 16'h0006;
  localparam int          STAGGER_SELECT_BIT    = 2;
  localparam int          LOCK_BIT    = 1;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  // byte address of a register index
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;

  typedef struct packed {
    logic [CH_N-1:0] match;
    logic [CH_N-1:0] level;
    logic [CH_N-1:0] mode3;
    logic            ovf;
  } cmp_event_t;

endpackage
`default_nettype wire

// ### rtl/stagger_slot_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module stagger_slot_ctrl (
  input  wire logic                                              ref_clk,
  input  wire logic                                              rst_b,
  input  wire logic                                              non_stagger_select,
  output logic [compare_single_event_stagger_pkg::SLOT_W-1:0] slot,
  output logic                                                   tick
);

  logic [compare_single_event_stagger_pkg::SLOT_W-1:0] slot_reg;
  logic [compare_single_event_stagger_pkg::SLOT_W-1:0] slot_next;
  logic                                                tick_reg;
  logic                                                tick_next;
  logic                                                slot_last;

  // ****************************************
  // operation cycle slot counter
  // ****************************************
  assign slot_last = slot_reg == compare_single_event_stagger_pkg::SLOT_W'(
                     compare_single_event_stagger_pkg::OP_CYCLE_CLKS - 1);
  assign slot_next = (non_stagger_select || slot_last) ? '0 : slot_reg + 3'h1; // R9
  assign tick_next = non_stagger_select || (slot_next == '0); // R13

  // slot and tick flops
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      slot_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      slot_reg <= slot_next;
      tick_reg <= tick_next;
    end
  end

  assign slot = slot_reg;
  assign tick = tick_reg;

endmodule
`default_nettype wire

// ### rtl/compare_single_event_stagger.sv
// Overview of operation
// [R1] sixteen software read/write single-event arm bits
// [R2] hardware clears arm bit after the event
// [R3] software: mode, value, select, then arm
// [R4] armed match acts fully, then disarms channel
// [R5] cleared arm bit blocks all compares of a selected channel
// [R6] control bit 2: 1 non-staggered, 0 staggered
// [R7] control bit 1 locks out port latch writes
// [R8] no latch writes when non-staggered or locked
// [R9] staggered operation cycle is eight clocks
// [R10] channel k switches k+1 clocks after match
// [R11] channels 8-15 staggered alongside 0-7
// [R12] compare outputs still drive alternate pin function
// [R13] non-staggered: outputs switch the following clock
// [R14] non-staggered overflow takes one extra clock
// [R15] mode 3 overflow clears outputs, staggered too
// [R16] pinless instance: latch lock has no effect
// [R17] per-channel select bit enables single-event behaviour
// [R18] select clear: arm ignored, every match acts
// [R19] software arm write beats hardware clear
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module compare_single_event_stagger #(
  parameter bit PINS_CONNECTED = 1'b1
) (
  input  wire logic                                          ref_clk,
  input  wire logic                                          rst_b,
  input  wire compare_single_event_stagger_pkg::axil_req_t   bus_req,
  output compare_single_event_stagger_pkg::axil_rsp_t        bus_rsp,
  input  wire compare_single_event_stagger_pkg::cmp_event_t  cmp_in,
  output logic                                               op_tick,
  output logic [15:0]                                        compare_out,
  output logic [15:0]                                        port_latch_we,
  output logic [15:0]                                        port_latch_data
);

  // ****************************************
  // declarations
  // ****************************************
  logic [15:0] arm_reg, arm_next, select_reg, ioc1_reg, ioc2_reg;
  logic [15:0] out_reg, out_next, pwe_reg, pwe_next;
  logic [15:0] pend_set_reg, pend_lvl_reg, pend_m3_reg;
  logic        pend_ovf_reg, ns_ovf_reg;
  logic        awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic [19:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic [2:0]  slot;
  logic        tick, non_stagger_select, lock, latch_ok, wr_fire, rd_fire, wr_ok, rd_ok;
  logic        wr_arm, wr_sel, wr_ioc1, wr_ioc2;
  logic [15:0] qual, arm_hw, stg_set, stg_lvl, stg_m3, lane_hit;
  logic [15:0] ev_set, ev_lvl, ev_rst, wr_val, rd_val;
  logic [7:0]  lane8;
  logic        stg_ovf;

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // register index decode
  function automatic logic hit(input logic [19:0] a, input logic [15:0] idx);
    return a == compare_single_event_stagger_pkg::byte_addr(idx);
  endfunction

  // ****************************************
  // operation cycle timing
  // ****************************************
  assign non_stagger_select = ioc2_reg[compare_single_event_stagger_pkg::STAGGER_SELECT_BIT]; // R6
  assign lock     = ioc2_reg[compare_single_event_stagger_pkg::LOCK_BIT]; // R7

  stagger_slot_ctrl u_slot (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .non_stagger_select (non_stagger_select),
    .slot     (slot),
    .tick     (tick)
  );

  // ****************************************
  // single-event qualification
  // ****************************************
  assign qual   = cmp_in.match & {16{tick}} & (~select_reg | arm_reg); // R5 R17 R18
  assign arm_hw = arm_reg & ~(qual & select_reg); // R2 R4

  // arm bit: software write wins on written bytes
  assign arm_next = wr_arm ? merge16(arm_hw, wdata_reg, wstrb_reg) : arm_hw; // R1 R19

  // ****************************************
  // staggered event routing
  // ****************************************
  assign stg_set  = tick ? qual : pend_set_reg;
  assign stg_lvl  = tick ? cmp_in.level : pend_lvl_reg;
  assign stg_m3   = tick ? cmp_in.mode3 : pend_m3_reg;
  assign stg_ovf  = tick ? cmp_in.ovf : pend_ovf_reg;
  assign lane8    = 8'(8'h01 << slot); // R10
  assign lane_hit = {lane8, lane8}; // R11

  // ****************************************
  // output value control
  // ****************************************
  assign ev_set = non_stagger_select ? qual : (stg_set & lane_hit); // R4 R13
  assign ev_lvl = non_stagger_select ? cmp_in.level : stg_lvl;
  assign ev_rst = non_stagger_select ? ({16{ns_ovf_reg}} & pend_m3_reg) // R14 R15
                           : ({16{stg_ovf}} & stg_m3 & lane_hit); // R15
  assign out_next = (out_reg & ~ev_set & ~ev_rst) | (ev_set & ev_lvl);

  // port latch writes only staggered, unlocked, pinned
  assign latch_ok = !non_stagger_select && !lock && PINS_CONNECTED; // R8 R16
  assign pwe_next = (ev_set | ev_rst) & {16{latch_ok}}; // R8

  // compare state flops
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      out_reg      <= compare_single_event_stagger_pkg::REG_RESET;
      pwe_reg      <= '0;
      pend_set_reg <= '0;
      pend_lvl_reg <= '0;
      pend_m3_reg  <= '0;
      pend_ovf_reg <= 1'b0;
      ns_ovf_reg   <= 1'b0;
    end else begin
      out_reg      <= out_next; // R12
      pwe_reg      <= pwe_next;
      pend_set_reg <= stg_set;
      pend_lvl_reg <= stg_lvl;
      pend_m3_reg  <= stg_m3;
      pend_ovf_reg <= stg_ovf;
      ns_ovf_reg   <= non_stagger_select && tick && cmp_in.ovf; // R14
    end
  end

  // ****************************************
  // bus slave: write path
  // ****************************************
  assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
  assign wr_arm  = wr_fire && hit(awaddr_reg, compare_single_event_stagger_pkg::IDX_ARM);
  assign wr_sel  = wr_fire && hit(awaddr_reg, compare_single_event_stagger_pkg::IDX_SELECT);
  assign wr_ioc1 = wr_fire && hit(awaddr_reg, compare_single_event_stagger_pkg::IDX_IOC1);
  assign wr_ioc2 = wr_fire && hit(awaddr_reg, compare_single_event_stagger_pkg::IDX_IOC2);
  assign wr_ok   = wr_arm || wr_sel || wr_ioc1 || wr_ioc2;

  // handshake and response flops
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= compare_single_event_stagger_pkg::RESP_OKAY;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
    end else begin
      if (awready_reg && bus_req.awvalid) begin
        awready_reg <= 1'b0;
        awaddr_reg  <= bus_req.awaddr;
      end
      if (wready_reg && bus_req.wvalid) begin
        wready_reg <= 1'b0;
        wdata_reg  <= bus_req.wdata;
        wstrb_reg  <= bus_req.wstrb;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_ok ? compare_single_event_stagger_pkg::RESP_OKAY
                            : compare_single_event_stagger_pkg::RESP_SLVERR;
      end
      if (bvalid_reg && bus_req.bready) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // software registers
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      arm_reg    <= compare_single_event_stagger_pkg::REG_RESET;
      select_reg <= compare_single_event_stagger_pkg::REG_RESET;
      ioc1_reg   <= compare_single_event_stagger_pkg::REG_RESET;
      ioc2_reg   <= compare_single_event_stagger_pkg::REG_RESET;
    end else begin
      arm_reg <= arm_next; // R1
      if (wr_sel) begin
        select_reg <= merge16(select_reg, wdata_reg, wstrb_reg); // R17
      end
      if (wr_ioc1) begin
        ioc1_reg <= wr_val; // R16
      end
      if (wr_ioc2) begin
        ioc2_reg <= wr_val;
      end
    end
  end

  // only stagger and lock bits are writable
  assign wr_val = merge16(wr_ioc1 ? ioc1_reg : ioc2_reg, wdata_reg, wstrb_reg)
                  & compare_single_event_stagger_pkg::IOC_RW_MASK;

  // ****************************************
  // bus slave: read path
  // ****************************************
  assign rd_fire = arready_reg && bus_req.arvalid;
  assign rd_val  = hit(bus_req.araddr, compare_single_event_stagger_pkg::IDX_ARM)    ? arm_reg :
                   hit(bus_req.araddr, compare_single_event_stagger_pkg::IDX_SELECT) ? select_reg :
                   hit(bus_req.araddr, compare_single_event_stagger_pkg::IDX_IOC1)   ? ioc1_reg :
                   hit(bus_req.araddr, compare_single_event_stagger_pkg::IDX_IOC2)   ? ioc2_reg :
                   hit(bus_req.araddr, compare_single_event_stagger_pkg::IDX_STATUS) ? out_reg : '0;
  assign rd_ok   = hit(bus_req.araddr, compare_single_event_stagger_pkg::IDX_ARM)
                || hit(bus_req.araddr, compare_single_event_stagger_pkg::IDX_SELECT)
                || hit(bus_req.araddr, compare_single_event_stagger_pkg::IDX_IOC1)
                || hit(bus_req.araddr, compare_single_event_stagger_pkg::IDX_IOC2)
                || hit(bus_req.araddr, compare_single_event_stagger_pkg::IDX_STATUS);

  // read handshake flops
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= compare_single_event_stagger_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= {16'h0000, rd_val};
      rresp_reg   <= rd_ok ? compare_single_event_stagger_pkg::RESP_OKAY
                           : compare_single_event_stagger_pkg::RESP_SLVERR;
    end else if (rvalid_reg && bus_req.rready) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign bus_rsp.awready = awready_reg;
  assign bus_rsp.wready  = wready_reg;
  assign bus_rsp.bvalid  = bvalid_reg;
  assign bus_rsp.bresp   = bresp_reg;
  assign bus_rsp.arready = arready_reg;
  assign bus_rsp.rvalid  = rvalid_reg;
  assign bus_rsp.rdata   = rdata_reg;
  assign bus_rsp.rresp   = rresp_reg;
  assign op_tick         = tick;
  assign compare_out     = out_reg;
  assign port_latch_we   = pwe_reg;
  assign port_latch_data = out_reg;

  // ****************************************
  // assertions
  // ****************************************
  property p_arm_clear;
    @(posedge ref_clk) disable iff (!rst_b)
    (|(qual & select_reg)) && !wr_arm |=> (arm_reg & $past(qual & select_reg)) == 16'h0000;
  endproperty
  a_arm_clear: assert property (p_arm_clear) else $error("arm bit not cleared after event"); // R2

  property p_disarmed;
    @(posedge ref_clk) disable iff (!rst_b)
    tick && non_stagger_select && cmp_in.match[0] && select_reg[0] && !arm_reg[0]
      |=> compare_out[0] == $past(compare_out[0]) && !ev_set[0];
  endproperty
  a_disarmed: assert property (p_disarmed) else $error("disarmed channel acted"); // R5

  property p_unrestricted;
    @(posedge ref_clk) disable iff (!rst_b)
    tick && non_stagger_select && cmp_in.match[1] && !select_reg[1] |=> compare_out[1] == $past(cmp_in.level[1]);
  endproperty
  a_unrestricted: assert property (p_unrestricted) else $error("plain channel match lost"); // R18 R13

  property p_no_latch;
    @(posedge ref_clk) disable iff (!rst_b)
    non_stagger_select || lock |=> port_latch_we == 16'h0000;
  endproperty
  a_no_latch: assert property (p_no_latch) else $error("port latch written while barred"); // R8

  property p_cycle8;
    @(posedge ref_clk) disable iff (!rst_b)
    !non_stagger_select && tick |=> (!tick || non_stagger_select) [*7];
  endproperty
  a_cycle8: assert property (p_cycle8) else $error("staggered cycle shorter than 8"); // R9

  property p_ch7;
    @(posedge ref_clk) disable iff (!rst_b)
    !non_stagger_select && tick && qual[7] |-> ##8 (non_stagger_select || compare_out[7] == $past(cmp_in.level[7], 8));
  endproperty
  a_ch7: assert property (p_ch7) else $error("channel 7 delay wrong"); // R10

  property p_ovf_pair;
    @(posedge ref_clk) disable iff (!rst_b)
    !non_stagger_select && tick && cmp_in.ovf && cmp_in.mode3[3] && cmp_in.mode3[11] && !qual[3] && !qual[11]
      |-> ##4 (non_stagger_select || (!compare_out[3] && !compare_out[11]));
  endproperty
  a_ovf_pair: assert property (p_ovf_pair) else $error("paired overflow reset misaligned"); // R11 R15

  property p_ns_ovf;
    @(posedge ref_clk) disable iff (!rst_b)
    (non_stagger_select && tick && cmp_in.ovf && cmp_in.mode3[0]) ##1 (non_stagger_select && !qual[0])
      |=> !compare_out[0];
  endproperty
  a_ns_ovf: assert property (p_ns_ovf) else $error("late overflow reset missing"); // R14

  property p_bhold;
    @(posedge ref_clk) disable iff (!rst_b)
    bvalid_reg && !bus_req.bready |=> bvalid_reg && $stable(bresp_reg);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");

  c_single: cover property (@(posedge ref_clk) disable iff (!rst_b) |(qual & select_reg));
  c_stagger_select_ovf: cover property (@(posedge ref_clk) disable iff (!rst_b) !non_stagger_select && |ev_rst);
  c_ns_match: cover property (@(posedge ref_clk) disable iff (!rst_b) non_stagger_select && |ev_set);
  c_latch: cover property (@(posedge ref_clk) disable iff (!rst_b) |port_latch_we);

endmodule
`default_nettype wire

// ### dv/port_latch_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port output latch and pin
// ****************************************
module port_latch_model (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [15:0] latch_we,
  input  wire logic [15:0] latch_data,
  input  wire logic [15:0] alt_out,
  input  wire logic        alt_sel,
  output logic      [15:0] latch_reg,
  output logic      [15:0] pin
);
  // bit-wise latch, written only where the strobe pulses
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      latch_reg <= 16'h0000;
    end else begin
      latch_reg <= (latch_we & latch_data) | (~latch_we & latch_reg);
    end
  end
  // pin shows the latch or the alternate output function
  assign pin = alt_sel ? alt_out : latch_reg;
endmodule
`default_nettype wire

// ### dv/compare_single_event_stagger_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module compare_single_event_stagger_tb_top;
  // ****************************************
  // signals
  // ****************************************
  localparam logic [15:0] A_ARM = compare_single_event_stagger_pkg::IDX_ARM;
  localparam logic [15:0] A_SEL = compare_single_event_stagger_pkg::IDX_SELECT;
  localparam logic [15:0] A_IO1 = compare_single_event_stagger_pkg::IDX_IOC1;
  localparam logic [15:0] A_IO2 = compare_single_event_stagger_pkg::IDX_IOC2;
  localparam logic [15:0] A_STS = compare_single_event_stagger_pkg::IDX_STATUS;
  localparam logic [1:0]  OK    = compare_single_event_stagger_pkg::RESP_OKAY;
  localparam logic [1:0]  ERR   = compare_single_event_stagger_pkg::RESP_SLVERR;
  logic                                         ref_clk;
  logic                                         rst_b;
  compare_single_event_stagger_pkg::axil_req_t  bus_req;
  compare_single_event_stagger_pkg::axil_rsp_t  bus_rsp;
  compare_single_event_stagger_pkg::cmp_event_t cmp_in;
  logic                                         op_tick;
  logic [15:0]                                  compare_out;
  logic [15:0]                                  port_latch_we;
  logic [15:0]                                  port_latch_data;
  logic [15:0]                                  latch_reg;
  logic [15:0]                                  pin;
  logic                                         alt_sel;
  logic                                         we_on;
  logic [15:0]                                  cur;
  int                                           n_fail;
  int                                           checks;

  // block and far-side latch
  compare_single_event_stagger u_compare_single_event_stagger (.ref_clk(ref_clk), .rst_b(rst_b),
    .bus_req(bus_req), .bus_rsp(bus_rsp), .cmp_in(cmp_in), .op_tick(op_tick), .compare_out(compare_out),
    .port_latch_we(port_latch_we), .port_latch_data(port_latch_data));
  port_latch_model u_port_latch_model (.ref_clk(ref_clk), .rst_b(rst_b), .latch_we(port_latch_we),
    .latch_data(port_latch_data), .alt_out(compare_out), .alt_sel(alt_sel), .latch_reg(latch_reg), .pin(pin));

  // clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ****************************************
  // common tasks
  // ****************************************
  task automatic end_of_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic bail;
    n_fail++;
    $display("wait ran out at %0t", $time);
    end_of_test();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one write: address and data together, response awaited
  task automatic wr(input logic [15:0] idx, input logic [15:0] d, input logic [1:0] er);
    int n;
    @(posedge ref_clk);
    bus_req.awaddr  <= {2'b00, idx, 2'b00};
    bus_req.wdata   <= {16'h0000, d};
    bus_req.wstrb   <= 4'hf;
    bus_req.awvalid <= 1'b1;
    bus_req.wvalid  <= 1'b1;
    bus_req.bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (bus_rsp.awready === 1'b1) bus_req.awvalid <= 1'b0;
      if (bus_rsp.wready === 1'b1) bus_req.wvalid <= 1'b0;
      if (bus_rsp.bvalid === 1'b1) break;
    end
    bus_req.bready <= 1'b0;
    if (n == 50) bail();
    chk(bus_rsp.bresp, er);
  endtask

  // one read, data and response taken at the answer edge
  task automatic rd(input logic [15:0] idx, input logic [15:0] ex, input logic [1:0] er);
    int n;
    @(posedge ref_clk);
    bus_req.araddr  <= {2'b00, idx, 2'b00};
    bus_req.arvalid <= 1'b1;
    bus_req.rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (bus_rsp.arready === 1'b1) bus_req.arvalid <= 1'b0;
      if (bus_rsp.rvalid === 1'b1) break;
    end
    bus_req.rready <= 1'b0;
    if (n == 50) bail();
    chk(bus_rsp.rdata, {16'h0000, ex});
    chk(bus_rsp.rresp, er);
  endtask

  // clocks from one tick to the next
  task automatic period(input int exp);
    int n;
    @(negedge ref_clk);
    for (n = 0; n < 20 && op_tick !== 1'b1; n++) @(negedge ref_clk);
    @(negedge ref_clk);
    for (n = 1; n < 20 && op_tick !== 1'b1; n++) @(negedge ref_clk);
    chk(n, exp);
  endtask

  // present an event for one tick, then follow outputs; base 0 means staggered
  task automatic fire(input logic [15:0] m, input logic [15:0] lv, input logic [15:0] m3, input logic ov,
                      input logic [15:0] nv, input int base);
    int n;
    int i;
    int k;
    int d;
    logic [15:0] e;
    logic [15:0] ew;
    @(posedge ref_clk);
    cmp_in <= {m, lv, m3, ov};
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      if (op_tick === 1'b1) break;
    end
    cmp_in <= '0;
    if (n == 20) bail();
    for (i = 1; i < 10; i++) begin
      @(negedge ref_clk);
      for (k = 0; k < 16; k++) begin
        d = (base == 0) ? (k % 8) + 1 : base;
        e[k] = (i >= d) ? nv[k] : cur[k];
        ew[k] = we_on && (i == d) && (nv[k] != cur[k]);
      end
      chk(compare_out, e);
      chk(port_latch_we & (nv ^ cur), ew);
    end
    cur = nv;
    chk(pin, cur);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic s_reset;
    rd(A_ARM, 16'h0000, OK);
    rd(A_SEL, 16'h0000, OK);
    rd(A_IO1, 16'h0000, OK);
    rd(A_IO2, 16'h0000, OK);
    rd(A_STS, 16'h0000, OK);
    rd(16'h0001, 16'h0000, ERR);
    wr(16'h0001, 16'hffff, ERR);
    period(8);
  endtask

  task automatic s_regs;
    wr(A_ARM, 16'ha5c3, OK);
    rd(A_ARM, 16'ha5c3, OK);
    wr(A_ARM, 16'h0000, OK);
    wr(A_IO1, 16'hffff, OK);
    rd(A_IO1, 16'h0006, OK);
    wr(A_IO2, 16'hfff9, OK);
    rd(A_IO2, 16'h0000, OK);
  endtask

  task automatic s_single;
    wr(A_SEL, 16'h0404, OK);
    wr(A_ARM, 16'h0404, OK);
    fire(16'h0404, 16'hffff, 16'h0000, 1'b0, 16'h0404, 0);
    rd(A_ARM, 16'h0000, OK);
    rd(A_STS, 16'h0404, OK);
    fire(16'h0404, 16'h0000, 16'h0000, 1'b0, 16'h0404, 0);
    chk(latch_reg, 16'h0404);
    wr(A_ARM, 16'h0400, OK);
    fire(16'h0404, 16'h0000, 16'h0000, 1'b0, 16'h0004, 0);
  endtask

  task automatic s_all;
    wr(A_SEL, 16'h0000, OK);
    fire(16'hffff, 16'hffff, 16'h0000, 1'b0, 16'hffff, 0);
    chk(latch_reg, 16'hffff);
    fire(16'h0000, 16'h0000, 16'hffff, 1'b1, 16'h0000, 0);
  endtask

  task automatic s_lock;
    wr(A_IO2, 16'h0002, OK);
    we_on = 1'b0;
    fire(16'h00ff, 16'h00ff, 16'h0000, 1'b0, 16'h00ff, 0);
    chk(latch_reg, 16'h0000);
    alt_sel <= 1'b0;
    @(negedge ref_clk);
    chk(pin, 16'h0000);
    alt_sel <= 1'b1;
  endtask

  task automatic s_nonstag;
    wr(A_IO2, 16'h0004, OK);
    period(1);
    wr(A_SEL, 16'h0001, OK);
    fire(16'h0f0f, 16'hff00, 16'h0000, 1'b0, 16'h0ff1, 1);
    fire(16'h0000, 16'h0000, 16'hffff, 1'b1, 16'h0000, 2);
    chk(latch_reg, 16'h0000);
  endtask

  // reset, then the scenarios in turn
  initial begin
    rst_b = 1'b0;
    bus_req = '0;
    cmp_in = '0;
    alt_sel = 1'b1;
    we_on = 1'b1;
    cur = 16'h0000;
    n_fail = 0;
    checks = 0;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    s_reset();
    s_regs();
    s_single();
    s_all();
    s_lock();
    s_nonstag();
    end_of_test();
  end
endmodule
`default_nettype wire
